// *** rtl/cbc_bus_command_controller.v ***
// Purpose: Decodes processor status into command and transceiver controls.
// Assumes: One 25 MHz clock; all pins pass a two-flop synchroniser.
// Notes: Every output is registered; pin responses lag three clocks.
// Behaviour
// - Decode select and status lines into six cycles; five drive commands.
// - Idle waits; status state lasts one clock, command states two; low status starts.
// - Ready sampled high at command state end repeats it; low ends the cycle.
// - Back-to-back cycles keep the same output timing as isolated ones.
// - Standard mode keeps direction and enable high between consecutive writes.
// - Shared mode delays read and acknowledge command assertion by one clock.
// - Shared mode delays write command assertion by two clocks.
// - Shared mode delays transceiver enable rise for writes by two clocks.
// - Shared mode always drops transceiver enable between cycles.
// - Address latch pulses for the whole status state, except halt.
// - Cascade enable lasts one clock beyond latch, acknowledge cycles only; unselected ones end it with latch.
// - Acknowledge cycles are timed like reads apart from cascade enable.
// - Unselected cycles give no command; past status state, no enable, direction high.
// - Unselected cycles ignore delay, enable and ready until status restarts.
// - Cycle select is latched at status state end.
// - Standard writes raise enable in status state, selected or not; unselected drops it after status state.
// - Shared mode: withdrawn grant floats commands and forces transceiver enable low.
// - Shared mode: granted bus restores enable at once, commands three edges later.
// - Standard mode async enable low forces commands and enable inactive.
// - Command delay sampled at status end and each following edge.
// - Command delay affects command strobes only.
// - Released delay asserts command at once, or at shared timing earliest.
// - Ready before delay release issues no command; controls end normally.
//
// Decided for this implementation: the AXI4-Lite slave port and the register offsets.
`include "cbc_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module cbc_bus_command_controller (
  input wire clock_i,                      // System clock, 25 MHz.
  input wire reset_i,                      // Asynchronous reset, high.
  input wire [7:0] s_axi_awaddr,           // Write address.
  input wire s_axi_awvalid,                // Write address valid.
  output reg s_axi_awready,                // Write address ready.
  input wire [31:0] s_axi_wdata,           // Write data.
  input wire [3:0] s_axi_wstrb,            // Write byte strobes.
  input wire s_axi_wvalid,                 // Write data valid.
  output reg s_axi_wready,                 // Write data ready.
  output reg [1:0] s_axi_bresp,            // Write response.
  output reg s_axi_bvalid,                 // Write response valid.
  input wire s_axi_bready,                 // Write response ready.
  input wire [7:0] s_axi_araddr,           // Read address.
  input wire s_axi_arvalid,                // Read address valid.
  output reg s_axi_arready,                // Read address ready.
  output reg [31:0] s_axi_rdata,           // Read data.
  output reg [1:0] s_axi_rresp,            // Read response.
  output reg s_axi_rvalid,                 // Read data valid.
  input wire s_axi_rready,                 // Read data ready.
  input wire status_line_zero_n_i,         // Processor status zero, low.
  input wire status_line_one_n_i,          // Processor status one, low.
  input wire memory_select_i,              // High memory, low I/O.
  input wire latched_cycle_select_i,       // Cycle select from decoder.
  input wire ready_n_i,                    // Ends cycle when low.
  input wire command_delay_i,              // Withholds commands when high.
  input wire async_command_enable_i,       // Standard mode enable.
  input wire shared_bus_grant_n_i,         // Shared mode grant, low.
  output reg interrupt_ack_command_n_o,    // Acknowledge strobe, low.
  output reg io_read_command_n_o,          // I/O read strobe, low.
  output reg io_write_command_n_o,         // I/O write strobe, low.
  output reg memory_read_command_n_o,      // Memory read strobe, low.
  output reg memory_write_command_n_o,     // Memory write strobe, low.
  output reg command_oe_o,                 // High while commands driven.
  output reg address_latch_o,              // Address latch strobe.
  output reg cascade_address_enable_o,     // Cascade address enable.
  output reg transceiver_enable_o,         // Data transceiver enable.
  output reg transfer_direction_o          // High write or idle, low read.
);

  localparam ST_IDLE = 2'b00;
  localparam ST_STAT = 2'b01;
  localparam ST_CMD1 = 2'b10;
  localparam ST_CMD2 = 2'b11;

  function is_read;
    input [2:0] t;
    begin
      is_read = (t == `CBC_CYC_INTERRUPT_ACK_COMMAND) || (t == `CBC_CYC_IORD) ||
                (t == `CBC_CYC_MRD);
    end
  endfunction

  function is_write;
    input [2:0] t;
    begin
      is_write = (t == `CBC_CYC_IOWR) || (t == `CBC_CYC_MWR);
    end
  endfunction

  function [1:0] sat_inc;
    input [1:0] c;
    begin
      sat_inc = (c == `CBC_CNT_MAX) ? c : c + 2'h1;
    end
  endfunction

  // Pin synchroniser; the first stage feeds only the second.
  reg [`CBC_PIN_W-1:0] meta_q;
  reg [`CBC_PIN_W-1:0] pin_q;
  wire [`CBC_PIN_W-1:0] pins;
  assign pins = {shared_bus_grant_n_i, async_command_enable_i,
                 command_delay_i, ready_n_i, latched_cycle_select_i,
                 memory_select_i, status_line_one_n_i,
                 status_line_zero_n_i};

  always @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      meta_q <= {`CBC_PIN_W{1'b1}};
      pin_q <= {`CBC_PIN_W{1'b1}};
    end else begin
      meta_q <= pins;
      pin_q <= meta_q;
    end
  end

  wire s0n = pin_q[`CBC_PIN_S0N];
  wire s1n = pin_q[`CBC_PIN_S1N];
  wire rdy_n = pin_q[`CBC_PIN_RDYN];
  wire dly = pin_q[`CBC_PIN_DLY];
  wire async_command_enable = pin_q[`CBC_PIN_CEN];
  wire aen_n = pin_q[`CBC_PIN_AENN];

  // Software state.
  reg shared_q;
  reg [31:0] cycles_q;
  reg aw_have_q;
  reg w_have_q;
  reg [7:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;

  // Sequencer state.
  reg [1:0] state_q, state_d;
  reg [2:0] type_q, type_d;
  reg sel_q, sel_d;
  reg rel_q, rel_d;
  reg [1:0] tc_q, tc_d;
  reg [1:0] grant_q, grant_d;
  reg hold_q, hold_d;
  reg done;

  always @* begin
    state_d = state_q;
    type_d = type_q;
    sel_d = sel_q;
    rel_d = rel_q;
    tc_d = tc_q;
    hold_d = 1'b0;
    done = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (!s0n || !s1n) begin
          state_d = ST_STAT;
          type_d = {pin_q[`CBC_PIN_MEM], s1n, s0n};
          sel_d = 1'b0;
          rel_d = 1'b0;
        end
      end
      ST_STAT: begin
        sel_d = pin_q[`CBC_PIN_SEL];
        rel_d = !dly;
        tc_d = 2'h0;
        // Unselected cycles wait for the next status, deaf to controls.
        state_d = pin_q[`CBC_PIN_SEL] ? ST_CMD1 : ST_IDLE;
      end
      ST_CMD1: begin
        state_d = ST_CMD2;
        rel_d = rel_q | !dly;
        tc_d = sat_inc(tc_q);
      end
      default: begin
        rel_d = rel_q | !dly;
        tc_d = sat_inc(tc_q);
        if (!rdy_n) begin
          state_d = ST_IDLE;
          done = 1'b1;
          hold_d = !shared_q && is_write(type_q);
        end else begin
          state_d = ST_CMD1;
        end
      end
    endcase
  end

  always @* begin
    grant_d = aen_n ? 2'h0 : sat_inc(grant_q);
  end

  // Outputs derived from next state so they stay registered.
  reg active, rd, wr, permit, gate, cmd_on;
  reg [1:0] need;
  reg [4:0] cmd_n_d;
  reg oe_d, ale_d, mce_d, den_d, dir_d;

  always @* begin
    rd = is_read(type_d);
    wr = is_write(type_d);
    active = (state_d == ST_CMD1 || state_d == ST_CMD2) && sel_d &&
             type_d != `CBC_CYC_HALT;
    need = 2'h0;
    if (shared_q && wr) begin
      need = `CBC_WR_DELAY_SHARED;
    end else if (shared_q && rd) begin
      need = `CBC_RD_DELAY_SHARED;
    end
    permit = shared_q ? (!aen_n && grant_d >= `CBC_GRANT_EDGES) : async_command_enable;
    gate = shared_q ? !aen_n : async_command_enable;
    cmd_on = active && rel_d && tc_d >= need && permit;
    cmd_n_d = 5'h1f;
    if (cmd_on) begin
      case (type_d)
        `CBC_CYC_INTERRUPT_ACK_COMMAND: cmd_n_d = 5'h1e;
        `CBC_CYC_IORD: cmd_n_d = 5'h1d;
        `CBC_CYC_IOWR: cmd_n_d = 5'h1b;
        `CBC_CYC_MRD: cmd_n_d = 5'h17;
        `CBC_CYC_MWR: cmd_n_d = 5'h0f;
        default: cmd_n_d = 5'h1f;
      endcase
    end
    oe_d = shared_q ? !aen_n : 1'b1;
    ale_d = state_d == ST_STAT && type_d != `CBC_CYC_HALT;
    mce_d = type_d == `CBC_CYC_INTERRUPT_ACK_COMMAND &&
            (state_d == ST_STAT ||
             (state_d == ST_CMD1 && tc_d == 2'h0));
    if (rd) begin
      den_d = active;
    end else if (!wr) begin
      den_d = 1'b0;
    end else if (shared_q) begin
      den_d = active && tc_d >= `CBC_DEN_DELAY_SHARED;
    end else begin
      den_d = state_d == ST_STAT || active || hold_d;
    end
    den_d = den_d && gate;
    dir_d = !(rd && (state_d == ST_STAT || active));
  end

  always @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= ST_IDLE;
      type_q <= `CBC_CYC_HALT;
      sel_q <= 1'b0;
      rel_q <= 1'b0;
      tc_q <= 2'h0;
      grant_q <= 2'h0;
      hold_q <= 1'b0;
      {memory_write_command_n_o, memory_read_command_n_o,
       io_write_command_n_o, io_read_command_n_o,
       interrupt_ack_command_n_o} <= 5'h1f;
      command_oe_o <= 1'b0;
      address_latch_o <= 1'b0;
      cascade_address_enable_o <= 1'b0;
      transceiver_enable_o <= 1'b0;
      transfer_direction_o <= 1'b1;
    end else begin
      state_q <= state_d;
      type_q <= type_d;
      sel_q <= sel_d;
      rel_q <= rel_d;
      tc_q <= tc_d;
      grant_q <= grant_d;
      hold_q <= hold_d;
      {memory_write_command_n_o, memory_read_command_n_o,
       io_write_command_n_o, io_read_command_n_o,
       interrupt_ack_command_n_o} <= cmd_n_d;
      command_oe_o <= oe_d;
      address_latch_o <= ale_d;
      cascade_address_enable_o <= mce_d;
      transceiver_enable_o <= den_d;
      transfer_direction_o <= dir_d;
    end
  end

  // Register bus slave: address and data may arrive in either order.
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire aw_now = aw_have_q || aw_take;
  wire w_now = w_have_q || w_take;
  wire [7:0] wa = aw_have_q ? aw_addr_q : s_axi_awaddr;
  wire [31:0] wd = w_have_q ? w_data_q : s_axi_wdata;
  wire [3:0] ws = w_have_q ? w_strb_q : s_axi_wstrb;
  wire do_wr = aw_now && w_now && !s_axi_bvalid;
  wire b_done = s_axi_bvalid && s_axi_bready;
  wire ar_take = s_axi_arvalid && s_axi_arready;

  wire [31:0] status_word;
  assign status_word = {24'h0, !aen_n, hold_q | rel_q, sel_q, type_q,
                        state_q};

  always @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      shared_q <= `CBC_CTRL_RESET;
      cycles_q <= 32'h0;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 8'h0;
      w_data_q <= 32'h0;
      w_strb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CBC_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `CBC_RESP_OKAY;
    end else begin
      if (done && sel_q) begin
        cycles_q <= cycles_q + 32'h1;
      end
      if (aw_take) begin
        aw_addr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
        if (wa == `CBC_REG_CTRL) begin
          if (ws[0]) begin
            shared_q <= wd[0];
          end
          s_axi_bresp <= `CBC_RESP_OKAY;
        end else if (wa == `CBC_REG_STATUS || wa == `CBC_REG_CYCLES) begin
          s_axi_bresp <= `CBC_RESP_OKAY;
        end else begin
          s_axi_bresp <= `CBC_RESP_SLVERR;
        end
      end else begin
        aw_have_q <= aw_now;
        w_have_q <= w_now;
        if (b_done) begin
          s_axi_bvalid <= 1'b0;
        end
        s_axi_awready <= !aw_now && !(s_axi_bvalid && !b_done);
        s_axi_wready <= !w_now && !(s_axi_bvalid && !b_done);
      end
      if (ar_take) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `CBC_RESP_OKAY;
        if (s_axi_araddr == `CBC_REG_CTRL) begin
          s_axi_rdata <= {31'h0, shared_q};
        end else if (s_axi_araddr == `CBC_REG_STATUS) begin
          s_axi_rdata <= status_word;
        end else if (s_axi_araddr == `CBC_REG_CYCLES) begin
          s_axi_rdata <= cycles_q;
        end else begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= `CBC_RESP_SLVERR;
        end
      end else if (s_axi_rvalid) begin
        if (s_axi_rready) begin
          s_axi_rvalid <= 1'b0;
          s_axi_arready <= 1'b1;
        end
      end else begin
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// *** inc/cbc_consts.vh ***
// Purpose: Shared constants of the processor bus command controller.
// Assumes: Included by bare name from the design file.
// Notes: Definitions only.
`ifndef CBC_CONSTS_VH
`define CBC_CONSTS_VH

// Register byte addresses on the register bus.
`define CBC_ADDR_W 8
`define CBC_REG_CTRL 8'h00
`define CBC_REG_STATUS 8'h04
`define CBC_REG_CYCLES 8'h08
`define CBC_CTRL_RESET 1'b0
`define CBC_RESP_OKAY 2'b00
`define CBC_RESP_SLVERR 2'b10

// Status register fields.
`define CBC_ST_STATE 1:0
`define CBC_ST_TYPE 4:2
`define CBC_ST_SEL 5
`define CBC_ST_CMD 6
`define CBC_ST_GRANT 7

// Positions in the synchronised pin vector.
`define CBC_PIN_W 8
`define CBC_PIN_S0N 0
`define CBC_PIN_S1N 1
`define CBC_PIN_MEM 2
`define CBC_PIN_SEL 3
`define CBC_PIN_RDYN 4
`define CBC_PIN_DLY 5
`define CBC_PIN_CEN 6
`define CBC_PIN_AENN 7

// Cycle codes as {memory select, status one, status zero}.
`define CBC_CYC_INTERRUPT_ACK_COMMAND 3'h0
`define CBC_CYC_IORD 3'h1
`define CBC_CYC_IOWR 3'h2
`define CBC_CYC_HALT 3'h4
`define CBC_CYC_MRD 3'h5
`define CBC_CYC_MWR 3'h6

// Clock counts of shared-bus timing.
`define CBC_RD_DELAY_SHARED 2'h1
`define CBC_WR_DELAY_SHARED 2'h2
`define CBC_DEN_DELAY_SHARED 2'h1
`define CBC_GRANT_EDGES 2'h3
`define CBC_CNT_MAX 2'h3

`endif

// *** verif/cbc_chk.sv ***
// Purpose: Port-level assertions of the bus command controller.
// Assumes: Sees only top-level ports; attached by the bind below.
// Notes: Command strobes are active low and read high when floated.
`timescale 1ns/1ps
`default_nettype none
module cbc_chk (
  input wire logic clock_i, // Clock.
  input wire logic reset_i, // Reset, high.
  input wire logic interrupt_ack_command_n_o, // Ack strobe.
  input wire logic io_read_command_n_o, // I/O read.
  input wire logic io_write_command_n_o, // I/O write.
  input wire logic memory_read_command_n_o, // Memory read.
  input wire logic memory_write_command_n_o, // Memory write.
  input wire logic command_oe_o, // Command drive.
  input wire logic address_latch_o, // Latch strobe.
  input wire logic cascade_address_enable_o, // Cascade enable.
  input wire logic transceiver_enable_o, // Transceiver enable.
  input wire logic transfer_direction_o // Direction.
);
  wire [4:0] cmd_n;
  assign cmd_n = {memory_write_command_n_o, memory_read_command_n_o,
    io_write_command_n_o, io_read_command_n_o, interrupt_ack_command_n_o};
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  sequence s_latch_pair;
    address_latch_o && cascade_address_enable_o;
  endsequence
  sequence s_cascade_tail;
    !address_latch_o && cascade_address_enable_o ##1
    !cascade_address_enable_o;
  endsequence
  AST_CMD_ONEHOT: assert property ($onehot0(~cmd_n))
    else $error("two command strobes active");
  AST_LATCH_PULSE: assert property (
    address_latch_o |=> !address_latch_o)
    else $error("latch strobe longer than one clock");
  AST_CASCADE_SPAN: assert property (
    $rose(cascade_address_enable_o) |-> s_latch_pair ##1 s_cascade_tail)
    else $error("cascade enable not one clock past latch");
  AST_FLOAT_IDLE: assert property (!command_oe_o |-> &cmd_n)
    else $error("command active while floated");
  AST_READ_DIR: assert property (
    !(cmd_n[0] && cmd_n[1] && cmd_n[3]) |-> !transfer_direction_o)
    else $error("read command with write direction");
  AST_WRITE_DIR: assert property (
    !(cmd_n[2] && cmd_n[4]) |-> transfer_direction_o)
    else $error("write command with read direction");
  AST_LATCH_NO_CMD: assert property (address_latch_o |-> &cmd_n)
    else $error("command during latch strobe");
  AST_CMD_ENABLE: assert property (
    !(&cmd_n) |-> transceiver_enable_o)
    else $error("command without transceiver enable");
  AST_RESET_IDLE: assert property ($fell(reset_i) |->
    &cmd_n && !transceiver_enable_o && transfer_direction_o)
    else $error("outputs not idle after reset");
endmodule
bind cbc_bus_command_controller cbc_chk cbc_chk_inst (
  .clock_i(clock_i), .reset_i(reset_i),
  .interrupt_ack_command_n_o(interrupt_ack_command_n_o),
  .io_read_command_n_o(io_read_command_n_o),
  .io_write_command_n_o(io_write_command_n_o),
  .memory_read_command_n_o(memory_read_command_n_o),
  .memory_write_command_n_o(memory_write_command_n_o),
  .command_oe_o(command_oe_o), .address_latch_o(address_latch_o),
  .cascade_address_enable_o(cascade_address_enable_o),
  .transceiver_enable_o(transceiver_enable_o),
  .transfer_direction_o(transfer_direction_o)
);
`default_nettype wire

// *** verif/cbc_cpu_model.sv ***
// Purpose: Processor-side model driving status, select and ready.
// Assumes: One bus cycle per go pulse; wait pairs set by the bench.
// Notes: Select is inverted once released so a stale latch shows up.
`timescale 1ns/1ps
`default_nettype none
module cbc_cpu_model (
  input wire logic clock_i, // Clock.
  input wire logic go_i, // Start a cycle.
  input wire logic [2:0] cyc_i, // Code {memory, s1, s0}.
  input wire logic sel_i, // Select for this cycle.
  input wire logic [1:0] waits_i, // Wait states.
  output logic status_line_zero_n_o, // Status zero.
  output logic status_line_one_n_o, // Status one.
  output logic memory_select_o, // Memory select.
  output logic cycle_select_o, // Decoder select.
  output logic ready_n_o, // Ready, low ends.
  output logic busy_o // Cycle running.
);
  initial begin
    {memory_select_o, status_line_one_n_o, status_line_zero_n_o} = 3'h3;
    cycle_select_o = 1'b0;
    ready_n_o = 1'b1;
    busy_o = 1'b0;
  end
  always @(posedge clock_i) begin
    if (go_i && !busy_o) begin
      busy_o <= 1'b1;
      {memory_select_o, status_line_one_n_o,
       status_line_zero_n_o} <= cyc_i;
      cycle_select_o <= sel_i;
      repeat (2) @(posedge clock_i);
      {status_line_one_n_o, status_line_zero_n_o} <= 2'h3;
      cycle_select_o <= ~sel_i;
      repeat (2 * waits_i) @(posedge clock_i);
      ready_n_o <= 1'b0;
      repeat (2) @(posedge clock_i);
      ready_n_o <= 1'b1;
      busy_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** verif/cbc_bus_command_controller_tb.sv ***
// Purpose: Self-checking bench of the bus command controller.
// Assumes: Processor model drives status; bench drives control pins.
// Notes: Timing is measured from the latch strobe, so pin lag cancels.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_count++; \
  $display("wrong value at %0t: %0h vs %0h", $time, (a), (b)); end end
module cbc_bus_command_controller_tb;
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rd;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic dly = 0, async_command_enable = 1, grant_n = 0, go = 0, sel = 0, clr = 0;
  logic [2:0] cyc = 3'h3;
  logic [1:0] waits = 2'h0, rr, br;
  logic [7:0] e_cmd, e_en;
  wire awready, wready, bvalid, arready, rvalid, oe, ale, cascade_address_enable, transceiver_enable, dir;
  wire s0_n, s1_n, mem, csel, rdy_n, busy;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [4:0] cmd_n;
  logic [4:0] mask;
  logic [7:0] t, t_ale, t_cmd, t_en, n_ale, n_mce;
  logic en_seen, fl_seen;
  int err_count = 0, n_checks = 0, cycles = 0;
  always #20 clock_i = ~clock_i;
  cbc_bus_command_controller cbc_bus_command_controller_inst (
    .clock_i(clock_i), .reset_i(reset_i), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .status_line_zero_n_i(s0_n),
    .status_line_one_n_i(s1_n), .memory_select_i(mem),
    .latched_cycle_select_i(csel), .ready_n_i(rdy_n),
    .command_delay_i(dly), .async_command_enable_i(async_command_enable),
    .shared_bus_grant_n_i(grant_n), .interrupt_ack_command_n_o(cmd_n[0]),
    .io_read_command_n_o(cmd_n[1]), .io_write_command_n_o(cmd_n[2]),
    .memory_read_command_n_o(cmd_n[3]), .memory_write_command_n_o(cmd_n[4]),
    .command_oe_o(oe), .address_latch_o(ale), .cascade_address_enable_o(cascade_address_enable),
    .transceiver_enable_o(transceiver_enable), .transfer_direction_o(dir));
  cbc_cpu_model cbc_cpu_model_inst (.clock_i(clock_i), .go_i(go),
    .cyc_i(cyc), .sel_i(sel), .waits_i(waits), .status_line_zero_n_o(s0_n),
    .status_line_one_n_o(s1_n), .memory_select_o(mem),
    .cycle_select_o(csel), .ready_n_o(rdy_n), .busy_o(busy));
  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Timing marks are relative to the clear, so one bus cycle per window.
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_count++;
      report_and_stop();
    end
    t <= t + 8'h01;
    if (clr) begin
      t <= 8'h00;
      mask <= 5'h00;
      n_ale <= 8'h00;
      n_mce <= 8'h00;
      en_seen <= 1'b0;
      fl_seen <= 1'b0;
    end else begin
      if (ale) t_ale <= t;
      n_ale <= n_ale + {7'h0, ale};
      n_mce <= n_mce + {7'h0, cascade_address_enable};
      if (mask == 5'h00 && cmd_n != 5'h1f) t_cmd <= t;
      mask <= mask | ~cmd_n;
      if (transceiver_enable && !en_seen) t_en <= t;
      en_seen <= en_seen | transceiver_enable;
      fl_seen <= fl_seen | !oe;
    end
  end
  task automatic axi_wr(input [7:0] a, input [31:0] d);
    @(posedge clock_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clock_i);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    br = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input [7:0] a, output [31:0] d, output [1:0] r);
    @(posedge clock_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clock_i);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic run(input [2:0] c, input logic s, input [1:0] w);
    @(posedge clock_i);
    cyc <= c;
    sel <= s;
    waits <= w;
    clr <= 1'b1;
    go <= 1'b1;
    @(posedge clock_i);
    clr <= 1'b0;
    go <= 1'b0;
    repeat (2) @(posedge clock_i);
    while (busy) @(posedge clock_i);
    repeat (6) @(posedge clock_i);
  endtask
  initial begin
    repeat (4) @(posedge clock_i);
    reset_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    axi_rd(8'h00, rd, rr);
    `CHK({rr, rd}, {2'b00, 32'h0})
    axi_rd(8'hfc, rd, rr);
    `CHK({rr, rd}, {2'b10, 32'h0})
    axi_wr(8'hfc, 32'h1);
    `CHK(br, 2'b10)
    for (int m = 0; m < 2; m++) begin
      axi_wr(8'h00, {31'h0, m[0]});
      `CHK(br, 2'b00)
      for (int i = 0; i < 7; i++) if (i != 3) begin
        run(i[2:0], 1'b1, 2'h1);
        `CHK(mask, (i == 4) ? 5'h00 : 5'h01 << ((i > 4) ? i - 2 : i))
        `CHK(n_ale, (i == 4) ? 8'h00 : 8'h01)
        `CHK(n_mce, (i == 0) ? 8'h02 : 8'h00)
        if (i != 4) begin
          e_cmd = (m == 0) ? 8'h01 : (i[1:0] == 2'h2) ? 8'h03 : 8'h02;
          e_en = (i[1:0] != 2'h2) ? 8'h01 : m ? 8'h02 : 8'h00;
          `CHK(t_cmd - t_ale, e_cmd)
          `CHK(t_en - t_ale, e_en)
        end
      end
    end
    axi_rd(8'h00, rd, rr);
    `CHK(rd, 32'h1)
    grant_n <= 1'b1;
    run(3'h5, 1'b1, 2'h1);
    `CHK({fl_seen, en_seen, mask}, {2'b10, 5'h00})
    grant_n <= 1'b0;
    run(3'h5, 1'b1, 2'h1);
    `CHK(mask, 5'h08)
    axi_wr(8'h00, 32'h0);
    run(3'h2, 1'b0, 2'h1);
    `CHK({n_ale, mask}, {8'h01, 5'h00})
    async_command_enable <= 1'b0;
    run(3'h1, 1'b1, 2'h1);
    `CHK({en_seen, mask}, {1'b0, 5'h00})
    async_command_enable <= 1'b1;
    dly <= 1'b1;
    run(3'h5, 1'b1, 2'h1);
    `CHK({en_seen, n_ale, mask}, {1'b1, 8'h01, 5'h00})
    fork
      run(3'h5, 1'b1, 2'h2);
      begin
        repeat (5) @(posedge clock_i);
        dly <= 1'b0;
      end
    join
    `CHK({t_cmd - t_ale > 8'h01, mask}, {1'b1, 5'h08})
    axi_rd(8'h08, rd, rr);
    `CHK(rd, 32'd17)
    report_and_stop();
  end
endmodule
`default_nettype wire
